//--- core/grlc_ctrl.sv
/*
 * Remote, local, lockout and clear handling of a bus instrument.
 * Assumes the acceptor handshake is done elsewhere: bus_in.dav is high
 * for one byte while the byte is held; bus lines arrive asynchronously and
 * active high. Front panel and settings logic lie outside.
 */
`timescale 1ns/1ns
`include "grlc_regs.svh"
module grlc_ctrl (
    input wire logic mclk,
    input wire logic rst,
    input wire grlc_pkg::grlc_bus_t bus_in,
    input wire logic [4:0] primary_addr,
    input wire logic user_defaults_valid,
    input wire grlc_pkg::grlc_settings_t user_defaults,
    input wire logic store_settings,
    input wire grlc_pkg::grlc_settings_t panel_settings,
    input wire logic [7:0] panel_keys,
    input wire logic power_key,
    output logic [7:0] panel_keys_gated,
    output logic power_key_out,
    output grlc_pkg::grlc_ind_t ind,
    output grlc_pkg::grlc_settings_t settings,
    output logic clear_pulse
);
    import grlc_pkg::*;

    // ======================================================================
    // Bus synchronisers
    // ======================================================================
    grlc_bus_t sync1_reg;
    grlc_bus_t sync2_reg;
    grlc_bus_t prev_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
        end else begin
            sync1_reg <= bus_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // ======================================================================
    // Command decode
    // ======================================================================
    function automatic logic is_addr(input logic [6:0] b, input logic [1:0] g,
                                     input logic [4:0] a);
        return b[6:5] == g && b[4:0] == a;
    endfunction

    wire logic [6:0] cmd = sync2_reg.data[6:0];
    wire logic ren = sync2_reg.ren;
    wire logic ifc = sync2_reg.ifc;
    wire logic cmd_stb = sync2_reg.atn && sync2_reg.dav && !prev_reg.dav;
    wire logic my_listen = cmd_stb && is_addr(cmd, `GRLC_LAG_BASE,
                                              primary_addr);
    wire logic my_talk = cmd_stb && is_addr(cmd, `GRLC_TAG_BASE,
                                            primary_addr);
    wire logic other_talk = cmd_stb && cmd[6:5] == `GRLC_TAG_BASE && !my_talk;
    wire logic unl = cmd_stb && cmd == `GRLC_CMD_UNL;
    wire logic unt = cmd_stb && cmd == `GRLC_CMD_UNT;
    wire logic gtl = cmd_stb && cmd == `GRLC_CMD_GTL_MASKED && ind.listen;
    wire logic llo = cmd_stb && cmd == `GRLC_CMD_LLO;
    wire logic dcl = cmd_stb && cmd == `GRLC_CMD_DCL;
    wire logic sdc = cmd_stb && cmd == `GRLC_CMD_SDC && ind.listen;

    // ======================================================================
    // Addressing
    // ======================================================================
    logic talk_reg;
    logic listen_reg;
    wire logic talk_next = ifc ? 1'b0 : my_talk ? 1'b1 :
        (unt || other_talk || my_listen) ? 1'b0 : talk_reg;
    wire logic listen_next = ifc ? 1'b0 : my_listen ? 1'b1 :
        (unl || my_talk) ? 1'b0 : listen_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            talk_reg <= 1'b0;
            listen_reg <= 1'b0;
        end else begin
            talk_reg <= talk_next;
            listen_reg <= listen_next;
        end
    end

    // ======================================================================
    // Remote and lockout state
    // ======================================================================
    grlc_rl_t rl_reg;
    grlc_rl_t rl_next;
    // Interface clear beats any addressing met in the same cycle.
    always_comb begin
        rl_next = rl_reg;
        unique case (rl_reg)
            GRLC_LOCAL: begin
                if (llo && ren) begin
                    rl_next = GRLC_LOCAL_LOCK;
                end else if (my_listen && ren && !ifc) begin
                    rl_next = GRLC_REMOTE;
                end
            end
            GRLC_REMOTE: begin
                if (llo && !ifc) begin
                    rl_next = GRLC_REMOTE_LOCK;
                end else if (llo) begin
                    rl_next = GRLC_LOCAL_LOCK;
                end else if (gtl || ifc) begin
                    rl_next = GRLC_LOCAL;
                end
            end
            GRLC_REMOTE_LOCK: begin
                if (gtl || ifc) begin
                    rl_next = GRLC_LOCAL_LOCK;
                end
            end
            GRLC_LOCAL_LOCK: begin
                if (my_listen && !ifc) begin
                    rl_next = GRLC_REMOTE_LOCK;
                end
            end
        endcase
        if (!ren) begin
            rl_next = GRLC_LOCAL;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            rl_reg <= GRLC_LOCAL;
        end else begin
            rl_reg <= rl_next;
        end
    end

    // ======================================================================
    // Settings and clear
    // ======================================================================
    localparam grlc_settings_t FACTORY = '{
        function_sel: `GRLC_DEF_FUNCTION, range_sel: `GRLC_DEF_RANGE,
        prefix_on: `GRLC_DEF_PREFIX, trigger_sel: `GRLC_DEF_TRIGGER,
        rate_sel: `GRLC_DEF_RATE, dig_filter_on: `GRLC_DEF_DIG_FILTER,
        exp_filter_on: `GRLC_DEF_EXP_FILTER, zero_on: `GRLC_DEF_ZERO,
        delay: `GRLC_DEF_DELAY, srq_mask: `GRLC_DEF_SRQ_MASK,
        mux_on: `GRLC_DEF_MUX, terminator: `GRLC_DEF_TERM};
    wire logic do_clear = dcl || sdc;
    wire grlc_settings_t clear_val = user_defaults_valid ? user_defaults :
        FACTORY;
    wire logic locked = rl_reg[1];
    // Panel stores are dropped in remote and under lockout; the clear wins any collision.
    wire logic panel_store = store_settings && !locked && !rl_reg[0];
    grlc_settings_t settings_reg;
    logic clear_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            settings_reg <= FACTORY;
            clear_reg <= 1'b0;
        end else begin
            clear_reg <= do_clear;
            if (do_clear) begin
                settings_reg <= clear_val;
            end else if (panel_store) begin
                settings_reg <= panel_settings;
            end
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign panel_keys_gated = locked ? 8'h00 : panel_keys;
    assign power_key_out = power_key;
    assign ind.remote = rl_reg[0];
    assign ind.lockout = locked;
    assign ind.talk = talk_reg;
    assign ind.listen = listen_reg;
    assign settings = settings_reg;
    assign clear_pulse = clear_reg;

    // ======================================================================
    // Checks
    // ======================================================================
    sequence s_addr_ren;
        my_listen && ren && rl_reg == GRLC_LOCAL && !llo;
    endsequence
    property p_remote_on_addr;
        @(posedge mclk) disable iff (rst) s_addr_ren |=> ind.remote;
    endproperty
    a_remote_on_addr: assert property (p_remote_on_addr)
        else $error("Addressed with remote enable but not remote.");
    property p_no_remote_unaddressed;
        @(posedge mclk) disable iff (rst)
            !ind.remote && !my_listen |=> !ind.remote;
    endproperty
    a_no_remote_unaddressed: assert property (p_no_remote_unaddressed)
        else $error("Remote entered without addressing.");
    property p_ifc_idle;
        @(posedge mclk) disable iff (rst)
            ifc |=> !ind.talk && !ind.listen && !ind.remote;
    endproperty
    a_ifc_idle: assert property (p_ifc_idle)
        else $error("Interface clear left talk, listen or remote.");
    property p_lock_keys;
        @(posedge mclk) disable iff (rst)
            ind.lockout |-> panel_keys_gated == 8'h00 &&
                power_key_out == power_key;
    endproperty
    a_lock_keys: assert property (p_lock_keys)
        else $error("Panel key passed under lockout.");
    property p_llo_needs_ren;
        @(posedge mclk) disable iff (rst) !ren |=> !ind.lockout;
    endproperty
    a_llo_needs_ren: assert property (p_llo_needs_ren)
        else $error("Lockout held without remote enable.");
    property p_gtl_keeps_lock;
        @(posedge mclk) disable iff (rst)
            ind.lockout && ren && gtl && !llo |=> ind.lockout && !ind.remote;
    endproperty
    a_gtl_keeps_lock: assert property (p_gtl_keeps_lock)
        else $error("Go to local mishandled under lockout.");
    property p_dcl_clears;
        @(posedge mclk) disable iff (rst)
            dcl |=> clear_pulse && settings == $past(clear_val);
    endproperty
    a_dcl_clears: assert property (p_dcl_clears)
        else $error("Device clear did not restore defaults.");
    property p_sdc_unaddressed;
        @(posedge mclk) disable iff (rst)
            cmd_stb && cmd == `GRLC_CMD_SDC && !ind.listen |=> !clear_pulse;
    endproperty
    a_sdc_unaddressed: assert property (p_sdc_unaddressed)
        else $error("Selective clear acted while unaddressed.");
    property p_ren_drop;
        @(posedge mclk) disable iff (rst)
            $fell(ren) |-> ##1 !ind.remote ##1 !ind.remote;
    endproperty
    a_ren_drop: assert property (p_ren_drop)
        else $error("Remote kept after remote enable fell.");
    property p_gtl_leaves_remote;
        @(posedge mclk) disable iff (rst)
            gtl |=> !ind.remote;
    endproperty
    a_gtl_leaves_remote: assert property (p_gtl_leaves_remote)
        else $error("Go to local left the device in remote.");
    property p_llo_locks;
        @(posedge mclk) disable iff (rst)
            llo && ren |=> ind.lockout;
    endproperty
    a_llo_locks: assert property (p_llo_locks)
        else $error("Lockout with remote enable not taken.");
    property p_keys_unlocked;
        @(posedge mclk) disable iff (rst)
            !ind.lockout |-> panel_keys_gated == panel_keys;
    endproperty
    a_keys_unlocked: assert property (p_keys_unlocked)
        else $error("Panel key blocked without lockout.");
    property p_sdc_clears;
        @(posedge mclk) disable iff (rst)
            sdc |=> clear_pulse && settings == $past(clear_val);
    endproperty
    a_sdc_clears: assert property (p_sdc_clears)
        else $error("Selective clear did not restore defaults.");
    property p_factory_clear;
        @(posedge mclk) disable iff (rst)
            do_clear && !user_defaults_valid |=> settings == FACTORY;
    endproperty
    a_factory_clear: assert property (p_factory_clear)
        else $error("Clear without a user set missed the factory set.");
    property p_user_clear;
        @(posedge mclk) disable iff (rst)
            do_clear && user_defaults_valid |=> settings == $past(user_defaults);
    endproperty
    a_user_clear: assert property (p_user_clear)
        else $error("Clear with a user set missed that set.");
    property p_lock_held;
        @(posedge mclk) disable iff (rst)
            ind.lockout && ren |=> ind.lockout;
    endproperty
    a_lock_held: assert property (p_lock_held)
        else $error("Lockout ended while remote enable stayed high.");
    property p_lock_keeps_settings;
        @(posedge mclk) disable iff (rst)
            (ind.lockout || ind.remote) && !do_clear |=> $stable(settings);
    endproperty
    a_lock_keeps_settings: assert property (p_lock_keeps_settings)
        else $error("Panel store taken in remote or lockout.");
    property p_talk_on_addr;
        @(posedge mclk) disable iff (rst)
            my_talk && !ifc |=> ind.talk;
    endproperty
    a_talk_on_addr: assert property (p_talk_on_addr)
        else $error("Own talk address not taken.");
    property p_listen_on_addr;
        @(posedge mclk) disable iff (rst)
            my_listen && !ifc |=> ind.listen;
    endproperty
    a_listen_on_addr: assert property (p_listen_on_addr)
        else $error("Own listen address not taken.");
    property p_remote_needs_ren;
        @(posedge mclk) disable iff (rst)
            !ren |=> !ind.remote;
    endproperty
    a_remote_needs_ren: assert property (p_remote_needs_ren)
        else $error("Remote held without remote enable.");
endmodule

//--- core/grlc_pkg.sv
/*
 * Types shared by the remote, local and clear controller.
 * Assumes the constants header is on the include path.
 */
`include "grlc_regs.svh"
package grlc_pkg;
    typedef enum logic [1:0] {
        GRLC_LOCAL = 2'b00,
        GRLC_REMOTE = 2'b01,
        GRLC_REMOTE_LOCK = 2'b11,
        GRLC_LOCAL_LOCK = 2'b10
    } grlc_rl_t;

    typedef struct packed {
        logic [3:0] function_sel;
        logic [2:0] range_sel;
        logic prefix_on;
        logic [2:0] trigger_sel;
        logic [2:0] rate_sel;
        logic dig_filter_on;
        logic exp_filter_on;
        logic zero_on;
        logic [15:0] delay;
        logic [7:0] srq_mask;
        logic mux_on;
        logic [1:0] terminator;
    } grlc_settings_t;

    typedef struct packed {
        logic atn;
        logic ren;
        logic ifc;
        logic dav;
        logic [7:0] data;
    } grlc_bus_t;

    typedef struct packed {
        logic remote;
        logic lockout;
        logic talk;
        logic listen;
    } grlc_ind_t;
endpackage

//--- core/grlc_regs.svh
/*
 * Constants for the remote, local and clear control of a bus instrument:
 * bus command bytes, address fields, default settings and timing counts.
 * Assumes inclusion by the package, the design module, the bus model and the bench.
 */
// Behaviour
// - Asserting remote enable alone never selects remote; remote follows only when the device is then addressed while remote enable stays true.
// - Interface clear sends the device to local and to talker idle and listener idle, turning off talk and listen indication.
// - Once lockout is accepted, every front panel control except power is ignored.
// - A lockout command takes effect only while remote enable is asserted.
// - Lockout ends only when remote enable drops; go to local leaves lockout standing.
// - Go to local received while addressed leaves remote and turns off the remote indicator.
// - Universal device clear acts without addressing.
// - Either clear restores the user defaults when stored, else the factory defaults.
// - Factory defaults: DC volts, top range, prefix on, continuous external trigger, line-cycle rate, filters, zero, delay, service request, multiplex and terminator as listed.
// - The device answers at its configured primary address, default 10.
`ifndef GRLC_REGS_SVH
`define GRLC_REGS_SVH

// ==========================================================================
// Command bytes, seven bits with the parity bit ignored, and address fields
// ==========================================================================
`define GRLC_CMD_GTL_MASKED 7'h01
`define GRLC_CMD_SDC 7'h04
`define GRLC_CMD_LLO 7'h11
`define GRLC_CMD_DCL 7'h14
`define GRLC_CMD_UNL 7'h3f
`define GRLC_CMD_UNT 7'h5f
`define GRLC_LAG_BASE 2'h1
`define GRLC_TAG_BASE 2'h2
`define GRLC_DEF_ADDR 5'h0a

// ==========================================================================
// Factory default settings
// ==========================================================================
`define GRLC_DEF_FUNCTION 4'h0
`define GRLC_DEF_RANGE 3'h5
`define GRLC_DEF_PREFIX 1'b1
`define GRLC_DEF_TRIGGER 3'h6
`define GRLC_DEF_RATE 3'h3
`define GRLC_DEF_DIG_FILTER 1'b0
`define GRLC_DEF_EXP_FILTER 1'b1
`define GRLC_DEF_ZERO 1'b0
`define GRLC_DEF_DELAY 16'h0000
`define GRLC_DEF_SRQ_MASK 8'h00
`define GRLC_DEF_MUX 1'b1
`define GRLC_DEF_TERM 2'h0

// ==========================================================================
// Timing
// ==========================================================================
`define GRLC_CLK_MHZ 100
`define GRLC_IFC_MIN_US 100
`define GRLC_IFC_CYCLES (`GRLC_IFC_MIN_US * `GRLC_CLK_MHZ)

`endif

//--- verification/grlc_bus_ctl_model.sv
/*
 * Behavioural bus controller that drives the instrument's bus lines.
 * Assumes the caller invokes its tasks in sequence from one process and
 * that the device samples the lines through its own synchronisers.
 */
`timescale 1ns/1ns
`include "grlc_regs.svh"
module grlc_bus_ctl_model (
    input wire logic mclk,
    output grlc_pkg::grlc_bus_t bus_out
);
    import grlc_pkg::*;

    // ======================================================================
    // Line state
    // ======================================================================
    initial begin
        bus_out = '0;
        bus_out.data = 8'hff;
    end

    // ======================================================================
    // Transfers
    // ======================================================================
    // Data is set a cycle ahead of the valid strobe and held until the strobe drops.
    // Once released, the data lines show the inverse of the last byte, so
    // a late sample cannot match by chance.
    task automatic send(input logic atn,
                        input logic [7:0] d);
        @(posedge mclk);
        bus_out.atn <= atn;
        bus_out.data <= d;
        @(posedge mclk);
        bus_out.dav <= 1'b1;
        repeat (4) @(posedge mclk);
        bus_out.dav <= 1'b0;
        bus_out.data <= ~d;
        bus_out.atn <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // Remote enable is set apart from addressing, before it in time.
    task automatic set_ren(input logic v);
        @(posedge mclk);
        bus_out.ren <= v;
        repeat (4) @(posedge mclk);
    endtask

    // Interface clear is held for the full minimum with no command byte.
    task automatic pulse_ifc();
        @(posedge mclk);
        bus_out.ifc <= 1'b1;
        repeat (`GRLC_IFC_CYCLES) @(posedge mclk);
        bus_out.ifc <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask
endmodule

//--- verification/test_gpib_remote_local_clear_ctrl.sv
/*
 * Self-checking bench for the remote, local and clear controller.
 * Assumes the controller answers within four cycles of a line change and
 * that the bus controller model drives all bus lines.
 */
`timescale 1ns/1ns
`include "grlc_regs.svh"
module test_gpib_remote_local_clear_ctrl;
    import grlc_pkg::*;

    // ======================================================================
    // Signals
    // ======================================================================
    logic mclk;
    logic rst = 1'b1;
    logic [4:0] primary_addr = `GRLC_DEF_ADDR;
    logic user_defaults_valid = 1'b0;
    logic store_settings = 1'b0;
    logic [7:0] panel_keys = 8'h00;
    logic power_key = 1'b0;
    logic [7:0] panel_keys_gated;
    logic power_key_out;
    logic clear_pulse;
    grlc_bus_t bus;
    grlc_ind_t ind;
    grlc_settings_t settings;
    grlc_settings_t user_defaults = '0;
    grlc_settings_t panel_settings = '0;
    grlc_settings_t factory;
    grlc_settings_t alt;
    grlc_settings_t alt2;
    int fail_count = 0;
    int comparisons = 0;
    int pulse_count = 0;

    assign factory = {`GRLC_DEF_FUNCTION, `GRLC_DEF_RANGE, `GRLC_DEF_PREFIX,
        `GRLC_DEF_TRIGGER, `GRLC_DEF_RATE, `GRLC_DEF_DIG_FILTER,
        `GRLC_DEF_EXP_FILTER, `GRLC_DEF_ZERO, `GRLC_DEF_DELAY,
        `GRLC_DEF_SRQ_MASK, `GRLC_DEF_MUX, `GRLC_DEF_TERM};

    grlc_ctrl i_grlc_ctrl (.mclk(mclk), .rst(rst), .bus_in(bus),
        .primary_addr(primary_addr),
        .user_defaults_valid(user_defaults_valid),
        .user_defaults(user_defaults), .store_settings(store_settings),
        .panel_settings(panel_settings), .panel_keys(panel_keys),
        .power_key(power_key), .panel_keys_gated(panel_keys_gated),
        .power_key_out(power_key_out), .ind(ind), .settings(settings),
        .clear_pulse(clear_pulse));

    grlc_bus_ctl_model i_grlc_bus_ctl_model (.mclk(mclk), .bus_out(bus));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (clear_pulse === 1'b1) pulse_count++;
    end

    // ======================================================================
    // Checking and closing
    // ======================================================================
    task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic t_reset();
        check(ind, 4'h0, "indicators after reset");
        check(settings, factory, "settings after reset");
    endtask

    // Remote enable alone must not select remote; a foreign address neither.
    task automatic t_remote();
        i_grlc_bus_ctl_model.set_ren(1'b1);
        check(ind.remote, 1'b0, "remote on enable alone");
        i_grlc_bus_ctl_model.send(1'b1, 8'h2b);
        check(ind.remote, 1'b0, "remote on other address");
        i_grlc_bus_ctl_model.send(1'b1, 8'h2a);
        check(ind.remote, 1'b1, "remote after addressing");
        check(ind.listen, 1'b1, "listen at own address");
    endtask

    // Go to local counts only while listen-addressed.
    task automatic t_gtl();
        i_grlc_bus_ctl_model.send(1'b1, 8'h3f);
        i_grlc_bus_ctl_model.send(1'b1, 8'h01);
        check(ind.remote, 1'b1, "unaddressed go to local");
        i_grlc_bus_ctl_model.send(1'b1, 8'h2a);
        i_grlc_bus_ctl_model.send(1'b1, 8'h01);
        check(ind.remote, 1'b0, "addressed go to local");
    endtask

    task automatic t_lockout();
        i_grlc_bus_ctl_model.set_ren(1'b0);
        i_grlc_bus_ctl_model.send(1'b1, 8'h11);
        check(ind.lockout, 1'b0, "lockout with enable low");
        i_grlc_bus_ctl_model.set_ren(1'b1);
        i_grlc_bus_ctl_model.send(1'b1, 8'h11);
        check(ind.lockout, 1'b1, "lockout with enable high");
        panel_keys <= 8'h5a;
        power_key <= 1'b1;
        repeat (2) @(posedge mclk);
        check(panel_keys_gated, 8'h00, "keys under lockout");
        check(power_key_out, 1'b1, "power under lockout");
        i_grlc_bus_ctl_model.send(1'b1, 8'h2a);
        i_grlc_bus_ctl_model.send(1'b1, 8'h01);
        check(ind.lockout, 1'b1, "lockout after go to local");
        check(ind.remote, 1'b0, "remote after local under lock");
        i_grlc_bus_ctl_model.send(1'b1, 8'h2a);
        check(ind.remote, 1'b1, "remote while locked");
        i_grlc_bus_ctl_model.set_ren(1'b0);
        check(ind.lockout, 1'b0, "lockout after enable drop");
        check(ind.remote, 1'b0, "remote after enable drop");
        check(panel_keys_gated, 8'h5a, "keys after unlock");
        power_key <= ~power_key;
        @(posedge mclk);
        check(power_key_out, 1'b0, "power pass through");
    endtask

    task automatic t_ifc();
        i_grlc_bus_ctl_model.set_ren(1'b1);
        i_grlc_bus_ctl_model.send(1'b1, 8'h2a);
        i_grlc_bus_ctl_model.send(1'b1, 8'h4a);
        check(ind.talk, 1'b1, "talk at own address");
        i_grlc_bus_ctl_model.send(1'b1, 8'h5f);
        check(ind.talk, 1'b0, "talk after untalk");
        i_grlc_bus_ctl_model.send(1'b1, 8'h4a);
        i_grlc_bus_ctl_model.send(1'b1, 8'h4b);
        check(ind.talk, 1'b0, "talk after other talker");
        i_grlc_bus_ctl_model.send(1'b1, 8'h4a);
        check(ind.talk, 1'b1, "talk readdressed");
        i_grlc_bus_ctl_model.pulse_ifc();
        check({ind.remote, ind.talk, ind.listen}, 3'h0, "after clear");
        i_grlc_bus_ctl_model.set_ren(1'b0);
    endtask

    // Both clears, factory and stored sets, and an unaddressed selective one.
    task automatic t_clear();
        int p;
        alt = factory;
        alt.range_sel = 3'h2;
        alt.zero_on = 1'b1;
        alt.delay = 16'h0123;
        alt2 = factory;
        alt2.function_sel = 4'h3;
        alt2.srq_mask = 8'h21;
        panel_settings <= alt;
        store_settings <= 1'b1;
        @(posedge mclk);
        store_settings <= 1'b0;
        repeat (4) @(posedge mclk);
        check(settings, alt, "stored panel settings");
        p = pulse_count;
        i_grlc_bus_ctl_model.send(1'b1, 8'h14);
        check(settings, factory, "universal clear");
        check(pulse_count, p + 1, "clear pulse count");
        user_defaults <= alt2;
        user_defaults_valid <= 1'b1;
        store_settings <= 1'b1;
        @(posedge mclk);
        store_settings <= 1'b0;
        i_grlc_bus_ctl_model.send(1'b1, 8'h3f);
        i_grlc_bus_ctl_model.send(1'b1, 8'h04);
        check(settings, alt, "unaddressed selective clear");
        i_grlc_bus_ctl_model.send(1'b1, 8'h2a);
        i_grlc_bus_ctl_model.send(1'b1, 8'h04);
        check(settings, alt2, "selective clear to user set");
    endtask

    // A strap change moves the device to a new address.
    task automatic t_addr();
        primary_addr <= 5'h15;
        i_grlc_bus_ctl_model.set_ren(1'b1);
        i_grlc_bus_ctl_model.send(1'b1, 8'h2a);
        check(ind.remote, 1'b0, "remote at old address");
        i_grlc_bus_ctl_model.send(1'b1, 8'h35);
        check(ind.remote, 1'b1, "remote at new address");
        i_grlc_bus_ctl_model.set_ren(1'b0);
        check(ind.remote, 1'b0, "remote after enable drop");
    endtask

    // ======================================================================
    // Main sequence and watchdog
    // ======================================================================
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_reset();
        t_remote();
        t_gtl();
        t_lockout();
        t_ifc();
        t_clear();
        t_addr();
        close_out();
    end

    // The run needs about 10300 cycles, most of it the interface clear.
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
endmodule
